// >>> rtl/sfp_front.sv
// Serial flash pin front end: select gating, lane routing, hardware reset
//
// Functional notes
// - Chip select high means deselected; no bits accepted from lanes.
// - While deselected every data lane is released to high impedance.
// - Chip select low selects device for instructions and read data.
// - After power-up, ignore instructions until chip select falls high to low.
// - Opcode is eight bits, always shifted in on lane zero alone.
// - Address/data use separate lanes single, lanes 0-1 dual, lanes 0-3 quad.
// - Serial clock alone times shifting in and out.
// - Reset pin low at least one microsecond aborts everything, back to power-on.
// - Reset pin acts regardless of configuration or state.
// - Running erase/program/status write continues after chip select rises.
// - Capture inputs on rising clock, launch outputs on falling clock.
// - Only clock modes 0 and 3 supported.
// - Quad phases honoured only while quad lane enable is set.
`timescale 1ns/10ps
module sfp_front
   import sfp_pkg::*;
#(
   parameter int RESET_CYC = RESET_MIN_CYC
) (
   input  wire logic                 i_ref_clk,
   input  wire logic                 i_resetn,
   input  wire logic                 i_clk_en,
   input  wire logic                 i_sck,
   input  wire logic                 i_cs_n,
   input  wire logic                 i_hw_reset_n,
   input  wire logic [LANES-1:0]     i_data_lane,
   output logic      [LANES-1:0]     o_data_lane,
   output logic      [LANES-1:0]     o_data_lane_oe,
   input  wire sfp_phase_s           i_phase_cfg,
   input  wire logic                 i_quad_lane_enable,
   input  wire logic [BYTE_BITS-1:0] i_tx_data,
   output logic      [BYTE_BITS-1:0] o_opcode,
   output logic                      o_opcode_valid,
   output logic      [BYTE_BITS-1:0] o_rx_data,
   output logic                      o_rx_valid,
   output logic                      o_tx_taken,
   output logic                      o_selected,
   output logic                      o_abort
);

   // ****************************************************************
   // State carriers by clock edge; the rising serial clock edge has two (link and held)
   // ****************************************************************
   typedef struct packed {
      logic                 cs_s1, cs_s2;
      logic                 rp_s1, rp_s2;
      logic                 armed;
      logic [RST_CNT_W-1:0] rst_cnt;
      logic                 abort;
      logic [2:0]           op_s, byte_s, tx_s;
      logic [BYTE_BITS-1:0] opcode, rx;
      logic                 op_v, rx_v, tx_v, sel;
   } sfp_ref_s;

   typedef struct packed {
      logic [BIT_CNT_W-1:0] cnt;
      logic                 op_done;
      logic [BYTE_BITS-1:0] sh;
      sfp_phase_s           cfg_s1, cfg_s2;
      logic                 qe_s1, qe_s2;
   } sfp_pos_s;

   // Event side of the capture edge; cleared only by reset or abort
   typedef struct packed {
      logic [BYTE_BITS-1:0] rx_byte, op;
      logic                 op_tgl, byte_tgl, tx_tgl;
   } sfp_hold_s;

   typedef struct packed {
      logic [BYTE_BITS-1:0] sh;
      sfp_lane_drv_s        drv;
   } sfp_neg_s;

   sfp_ref_s  ref_ff, nxt_ref;
   sfp_pos_s  pos_ff, nxt_pos;
   sfp_hold_s hold_ff, nxt_hold;
   sfp_neg_s  neg_ff, nxt_neg;
   logic      link_rst;
   logic      hold_rst;

   // ****************************************************************
   // Lane helpers
   // ****************************************************************
   // Bits moved per clock in the current phase
   function automatic logic [BIT_CNT_W-1:0] step(input logic od, input sfp_width_e w);
      if (!od) begin
         step = 4'h1;
      end else if (w == SFP_W_QUAD) begin
         step = 4'h4;
      end else if (w == SFP_W_DUAL) begin
         step = 4'h2;
      end else begin
         step = 4'h1;
      end
   endfunction

   // Input bits of one clock, most significant lane first
   function automatic logic [3:0] lane_in(input logic od, input sfp_width_e w,
                                          input logic [3:0] l);
      if (od && w == SFP_W_QUAD) begin
         lane_in = l;
      end else if (od && w == SFP_W_DUAL) begin
         lane_in = {2'h0, l[1], l[0]};
      end else begin
         lane_in = {3'h0, l[0]};
      end
   endfunction

   // Phase is usable unless quad is asked without the enable
   function automatic logic phase_ok(input sfp_phase_s c, input logic qe);
      phase_ok = (c.width != SFP_W_QUAD) || qe;
   endfunction

   // ****************************************************************
   // Link reset
   // ****************************************************************
   // Link flops clear the instant select rises, so lanes float at once
   assign link_rst = i_cs_n | ref_ff.abort | ~ref_ff.armed;
   // Toggles must outlive the select rise, or the last event is lost
   assign hold_rst = ~ref_ff.armed;

   // ****************************************************************
   // Rising edge: capture side
   // ****************************************************************
   always_comb begin
      logic [BIT_CNT_W-1:0] st;
      logic [BIT_CNT_W:0]   sum;
      logic                 ok;
      nxt_pos = pos_ff;
      nxt_hold = hold_ff;
      st  = step(pos_ff.op_done, pos_ff.cfg_s2.width);
      ok  = !pos_ff.op_done || phase_ok(pos_ff.cfg_s2, pos_ff.qe_s2);
      sum = {1'b0, pos_ff.cnt} + {1'b0, st};
      // Config settles during the eight opcode clocks
      nxt_pos.cfg_s1 = i_phase_cfg;
      nxt_pos.cfg_s2 = pos_ff.cfg_s1;
      nxt_pos.qe_s1  = i_quad_lane_enable;
      nxt_pos.qe_s2  = pos_ff.qe_s1;
      if (ok) begin
         nxt_pos.sh  = (pos_ff.sh << st) |
                       {4'h0, lane_in(pos_ff.op_done, pos_ff.cfg_s2.width, i_data_lane)};
         nxt_pos.cnt = sum[BIT_CNT_W-1:0];
         if (sum[BIT_CNT_W-1:0] == 4'(BYTE_BITS)) begin
            nxt_pos.cnt = '0;
            if (!pos_ff.op_done) begin
               nxt_hold.op     = nxt_pos.sh;
               nxt_pos.op_done = 1'b1;
               nxt_hold.op_tgl = ~hold_ff.op_tgl;
            end else if (pos_ff.cfg_s2.dir_out) begin
               nxt_hold.tx_tgl = ~hold_ff.tx_tgl;
            end else begin
               nxt_hold.rx_byte  = nxt_pos.sh;
               nxt_hold.byte_tgl = ~hold_ff.byte_tgl;
            end
         end
      end
   end

   // Capture on rising serial clock only
   always_ff @(posedge i_sck or posedge link_rst) begin
      if (link_rst) begin
         pos_ff <= '0;
      end else begin
         pos_ff <= nxt_pos;
      end
   end

   // Held bytes and toggles survive the frame end for the crossing
   always_ff @(posedge i_sck or posedge hold_rst) begin
      if (hold_rst) begin
         hold_ff <= '0;
      end else begin
         hold_ff <= nxt_hold;
      end
   end

   // ****************************************************************
   // Falling edge: launch side
   // ****************************************************************
   always_comb begin
      logic [BYTE_BITS-1:0] src;
      sfp_width_e           w;
      nxt_neg = neg_ff;
      src = neg_ff.sh;
      w = pos_ff.cfg_s2.width;
      nxt_neg.drv.oe = '0;
      if (pos_ff.op_done && pos_ff.cfg_s2.dir_out && phase_ok(pos_ff.cfg_s2, pos_ff.qe_s2)) begin
         // Byte boundary reloads; i_tx_data must be steady here
         src = (pos_ff.cnt == '0) ? i_tx_data : neg_ff.sh;
         if (w == SFP_W_QUAD) begin
            nxt_neg.drv.out = src[7:4];
            nxt_neg.drv.oe  = 4'hf;
            nxt_neg.sh      = src << 4;
         end else if (w == SFP_W_DUAL) begin
            nxt_neg.drv.out = {2'h0, src[7:6]};
            nxt_neg.drv.oe  = 4'h3;
            nxt_neg.sh      = src << 2;
         end else begin
            nxt_neg.drv.out = {2'h0, src[7], 1'b0};     // Separate output lane
            nxt_neg.drv.oe  = 4'h2;
            nxt_neg.sh      = src << 1;
         end
      end
   end

   // Launch on falling serial clock; cleared lanes float
   always_ff @(negedge i_sck or posedge link_rst) begin
      if (link_rst) begin
         neg_ff <= '0;
      end else begin
         neg_ff <= nxt_neg;
      end
   end

   assign o_data_lane    = neg_ff.drv.out;
   assign o_data_lane_oe = neg_ff.drv.oe;

   // ****************************************************************
   // Reference side: select, reset pin, event crossing
   // ****************************************************************
   always_comb begin
      nxt_ref = ref_ff;
      nxt_ref.cs_s1  = i_cs_n;
      nxt_ref.cs_s2  = ref_ff.cs_s1;
      nxt_ref.rp_s1  = i_hw_reset_n;
      nxt_ref.rp_s2  = ref_ff.rp_s1;
      nxt_ref.op_s   = {ref_ff.op_s[1:0], hold_ff.op_tgl};
      nxt_ref.byte_s = {ref_ff.byte_s[1:0], hold_ff.byte_tgl};
      nxt_ref.tx_s   = {ref_ff.tx_s[1:0], hold_ff.tx_tgl};
      nxt_ref.sel    = ~ref_ff.cs_s2 & ref_ff.armed & ~ref_ff.abort;
      // Armed once select has been seen high
      if (ref_ff.cs_s2) begin
         nxt_ref.armed = 1'b1;
      end
      // Low pulse must last the full count; any state, any setting
      if (ref_ff.rp_s2) begin
         nxt_ref.rst_cnt = '0;
         nxt_ref.abort   = 1'b0;
      end else if (ref_ff.rst_cnt == RST_CNT_W'(RESET_CYC)) begin
         nxt_ref.abort = 1'b1;
         nxt_ref.armed = 1'b0;
      end else begin
         nxt_ref.rst_cnt = ref_ff.rst_cnt + 1'b1;
      end
      nxt_ref.op_v = ref_ff.op_s[2] ^ ref_ff.op_s[1];
      nxt_ref.rx_v = ref_ff.byte_s[2] ^ ref_ff.byte_s[1];
      nxt_ref.tx_v = ref_ff.tx_s[2] ^ ref_ff.tx_s[1];
      // Chains restart with the cleared toggles, so no false event
      if (!ref_ff.armed) begin
         nxt_ref.op_s   = '0;
         nxt_ref.byte_s = '0;
         nxt_ref.tx_s   = '0;
         nxt_ref.op_v   = 1'b0;
         nxt_ref.rx_v   = 1'b0;
         nxt_ref.tx_v   = 1'b0;
      end
      if (nxt_ref.op_v) begin
         nxt_ref.opcode = hold_ff.op;
      end
      if (nxt_ref.rx_v) begin
         nxt_ref.rx = hold_ff.rx_byte;
      end
   end

   // Select rising touches only the link; internal jobs are not aborted
   always_ff @(posedge i_ref_clk) begin
      if (!i_resetn) begin
         ref_ff <= '0;
      end else if (i_clk_en) begin
         ref_ff <= nxt_ref;
      end
   end

   assign o_opcode       = ref_ff.opcode;
   assign o_opcode_valid = ref_ff.op_v;
   assign o_rx_data      = ref_ff.rx;
   assign o_rx_valid     = ref_ff.rx_v;
   assign o_tx_taken     = ref_ff.tx_v;
   assign o_selected     = ref_ff.sel;
   assign o_abort        = ref_ff.abort;
endmodule

// >>> rtl/sfp_pkg.sv
// Shared constants and carrier types for the serial flash pin front end
package sfp_pkg;
   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam int REF_CLK_PERIOD_NS = 10;
   localparam int RESET_MIN_NS      = 1000;
   // A least time rounds up to whole cycles
   localparam int RESET_MIN_CYC     = (RESET_MIN_NS + REF_CLK_PERIOD_NS - 1) / REF_CLK_PERIOD_NS;
   localparam int RST_CNT_W         = $clog2(RESET_MIN_CYC + 1);

   // ****************************************************************
   // Frame layout
   // ****************************************************************
   localparam int OPCODE_BITS = 8;
   localparam int BYTE_BITS   = 8;
   localparam int LANES       = 4;
   localparam int BIT_CNT_W   = 4;

   // Lane width of the phases after the opcode
   typedef enum logic [1:0] {
      SFP_W_SINGLE,
      SFP_W_DUAL,
      SFP_W_QUAD
   } sfp_width_e;

   // Phase configuration handed in by the instruction decoder
   typedef struct packed {
      logic       dir_out;
      sfp_width_e width;
   } sfp_phase_s;

   // Serial lane pins, two drive signals (out, oe) per two-way pin
   typedef struct packed {
      logic [LANES-1:0] out;
      logic [LANES-1:0] oe;
   } sfp_lane_drv_s;
endpackage

// >>> tb/sfp_front_properties.sv
// Pin checks for the flash front end
`timescale 1ns/10ps
module sfp_front_checker
   import sfp_pkg::*;
#(
   parameter int RESET_CYC = RESET_MIN_CYC
) (
   input wire logic             i_ref_clk,
   input wire logic             i_resetn,
   input wire logic             i_cs_n,
   input wire logic             i_hw_reset_n,
   input wire sfp_phase_s       i_phase_cfg,
   input wire logic             i_quad_lane_enable,
   input wire logic [LANES-1:0] o_data_lane_oe,
   input wire logic             o_opcode_valid,
   input wire logic             o_selected,
   input wire logic             o_abort
);
   // ********
   // Checks
   // ********
   int low_cnt;
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_resetn);
   // Run length of the reset pin held low
   always_ff @(posedge i_ref_clk) begin
      if (!i_resetn || i_hw_reset_n) low_cnt <= 0;
      else low_cnt <= low_cnt + 1;
   end
   property p_float; i_cs_n && $past(i_cs_n) |-> o_data_lane_oe == 4'h0; endproperty
   a_float: assert property (p_float) else $error("lane driven unselected");
   property p_unsel; i_cs_n [*5] |-> !o_selected; endproperty
   a_unsel: assert property (p_unsel) else $error("selected with cs high");
   property p_ab_min; $rose(o_abort) |-> $past(low_cnt, 2) >= RESET_CYC - 1; endproperty
   a_ab_min: assert property (p_ab_min) else $error("abort too early");
   property p_ab_max; low_cnt == RESET_CYC + 5 |-> o_abort; endproperty
   a_ab_max: assert property (p_ab_max) else $error("abort missing");
   property p_ab_sel; o_abort |-> ##1 !o_selected; endproperty
   a_ab_sel: assert property (p_ab_sel) else $error("selected in abort");
   property p_ab_end; o_abort && i_hw_reset_n |-> ##[1:5] !o_abort; endproperty
   a_ab_end: assert property (p_ab_end) else $error("abort stuck");
   property p_qoff; !i_quad_lane_enable && i_phase_cfg.width == SFP_W_QUAD
      |-> o_data_lane_oe == 4'h0; endproperty
   a_qoff: assert property (p_qoff) else $error("quad drive disabled");
   property p_upper; i_phase_cfg.width != SFP_W_QUAD |-> o_data_lane_oe[3:2] == 2'h0; endproperty
   a_upper: assert property (p_upper) else $error("upper lanes driven");
   property p_single; i_phase_cfg.width == SFP_W_SINGLE |-> !o_data_lane_oe[0]; endproperty
   a_single: assert property (p_single) else $error("lane zero driven");
   property p_wr; !i_phase_cfg.dir_out |-> o_data_lane_oe == 4'h0; endproperty
   a_wr: assert property (p_wr) else $error("driven in write");
   property p_oppls; o_opcode_valid |=> !o_opcode_valid; endproperty
   a_oppls: assert property (p_oppls) else $error("opcode pulse long");
endmodule
bind sfp_front sfp_front_checker #(.RESET_CYC(RESET_CYC)) i_sfp_front_checker (
   .i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_cs_n(i_cs_n), .i_hw_reset_n(i_hw_reset_n),
   .i_phase_cfg(i_phase_cfg), .i_quad_lane_enable(i_quad_lane_enable),
   .o_data_lane_oe(o_data_lane_oe), .o_opcode_valid(o_opcode_valid),
   .o_selected(o_selected), .o_abort(o_abort));

// >>> tb/sfp_host_model.sv
// Mode 0 and mode 3 host model for the flash front end
`timescale 1ns/10ps
module sfp_host_model (
   input  wire logic [3:0] i_lane,
   output logic            o_sck,
   output logic            o_cs_n,
   output logic [3:0]      o_lane
);
   // ********
   // Frames
   // ********
   // Clock idles low; released lanes toggle so stale bits never pass
   initial begin
      o_sck = 1'b0;
      o_cs_n = 1'b1;
      o_lane = 4'h0;
   end
   // Idle level between frames: low for mode 0, high for mode 3
   task automatic idle(input logic level);
      o_sck = level;
   endtask
   // One clock from idle and back; lanes read on the rise, held 1 ns after the return edge
   task automatic tick(output logic [3:0] smp);
      #31 o_sck = ~o_sck;
      if (o_sck) smp = i_lane;
      #32 o_sck = ~o_sck;
      if (o_sck) smp = i_lane;
      #1;
   endtask
   // Opcode on lane zero, then one byte over n lanes
   task automatic frame(input logic [7:0] op, input int n, input logic rdd,
                        input logic [7:0] wd, output logic [7:0] rd);
      logic [3:0] s;
      int k;
      int m;
      m = (1 << n) - 1;
      rd = 8'h00;
      #1.3 o_cs_n = 1'b0;
      for (k = 0; k < 8; k++) begin
         o_lane = {~o_lane[3:1], op[7-k]};
         tick(s);
      end
      for (k = 0; k < 8 / n; k++) begin
         o_lane = rdd ? ~o_lane : (~o_lane & ~4'(m)) | 4'((int'(wd) >> (8 - n * (k + 1))) & m);
         tick(s);
         rd = 8'((int'(rd) << n) | (n == 1 ? int'(s[1]) : int'(s) & m));
      end
      #32 o_cs_n = 1'b1;
      #64;
   endtask
   // Clock pulses with select high
   task automatic stray();
      logic [3:0] s;
      repeat (8) tick(s);
   endtask
endmodule

// >>> tb/test_sfp_front.sv
// Self-checking bench for the flash front end
`timescale 1ns/10ps
module test_sfp_front;
   import sfp_pkg::*;
   localparam int RCYC = 4;
   logic       i_ref_clk, i_resetn, i_hw_reset_n, qe, sck, cs_n, o_abort, o_selected;
   logic       o_opcode_valid, o_rx_valid, o_tx_taken;
   logic [3:0] host_lane, lane_w, o_data_lane, oe;
   logic [7:0] tx, o_opcode, o_rx_data, rd;
   sfp_phase_s cfg;
   int         mismatches, num_checks, cyc, op_q[$], rx_q[$], tx_cnt, tx_exp, sel_cyc;
   // Lane wire: whoever enables drives
   assign lane_w = (oe & o_data_lane) | (~oe & host_lane);
   sfp_front #(.RESET_CYC(RCYC)) i_sfp_front (
      .i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_clk_en(1'b1), .i_sck(sck), .i_cs_n(cs_n),
      .i_hw_reset_n(i_hw_reset_n), .i_data_lane(lane_w), .o_data_lane(o_data_lane),
      .o_data_lane_oe(oe), .i_phase_cfg(cfg), .i_quad_lane_enable(qe), .i_tx_data(tx),
      .o_opcode(o_opcode), .o_opcode_valid(o_opcode_valid), .o_rx_data(o_rx_data),
      .o_rx_valid(o_rx_valid), .o_tx_taken(o_tx_taken), .o_selected(o_selected),
      .o_abort(o_abort));
   sfp_host_model i_sfp_host_model (.i_lane(lane_w), .o_sck(sck), .o_cs_n(cs_n),
      .o_lane(host_lane));
   always #5 i_ref_clk = ~i_ref_clk;
   // ********
   // Checking
   // ********
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic summarize();
      $display("checks=%0d mismatches=%0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // Model queues against events; extra opcodes find an empty queue, extra bytes go unchecked
   always @(posedge i_ref_clk) begin
      cyc <= cyc + 1;
      if (o_tx_taken === 1'b1) tx_cnt <= tx_cnt + 1;
      if (o_selected === 1'b1) sel_cyc <= sel_cyc + 1;
      if (o_opcode_valid === 1'b1) check(o_opcode, op_q.size() ? 8'(op_q.pop_front()) : 8'hxx);
      if (o_rx_valid === 1'b1 && rx_q.size() > 0) check(o_rx_data, 8'(rx_q.pop_front()));
      if (cyc == 30000) begin
         mismatches++;
         summarize();
      end
   end
   // One frame of n lanes with random opcode and byte
   task automatic run(input int n, input logic dir, input logic q);
      logic [7:0] op;
      logic [7:0] wd;
      op = 8'($urandom);
      wd = 8'($urandom);
      @(posedge i_ref_clk);
      cfg.dir_out <= dir;
      cfg.width <= sfp_width_e'(n >> 1);
      qe <= q;
      tx <= wd;
      op_q.push_back(op);
      if (!dir && (n < 4 || q)) rx_q.push_back(wd);
      if (dir && (n < 4 || q)) tx_exp++;
      repeat (2) @(posedge i_ref_clk);
      i_sfp_host_model.frame(op, n, dir, wd, rd);
      if (dir && (n < 4 || q)) check(rd, wd);
   endtask
   // Reset pin low for len cycles
   task automatic pulse(input int len, input logic [7:0] exp);
      @(posedge i_ref_clk);
      i_hw_reset_n <= 1'b0;
      repeat (len) @(posedge i_ref_clk);
      check({7'h0, o_abort}, exp);
      i_hw_reset_n <= 1'b1;
   endtask
   initial begin
      {i_ref_clk, i_resetn, qe, cyc, mismatches, num_checks} = '0;
      {i_hw_reset_n, tx, cfg} = {1'b1, 11'h0};
      {tx_cnt, tx_exp, sel_cyc} = '0;
      void'($urandom(30));
      repeat (16) @(posedge i_ref_clk);
      i_resetn <= 1'b1;
      repeat (4) @(posedge i_ref_clk);
      for (int n = 1; n <= 4; n = n * 2) begin
         run(n, 1'b0, 1'b1);
         run(n, 1'b1, 1'b1);
      end
      $display("test lane_modes done");
      i_sfp_host_model.idle(1'b1);
      run(2, 1'b0, 1'b1);
      run(4, 1'b1, 1'b1);
      run(1, 1'b1, 1'b1);
      i_sfp_host_model.idle(1'b0);
      $display("test mode3 done");
      run(4, 1'b0, 1'b0);
      run(4, 1'b1, 1'b0);
      $display("test quad_off done");
      i_sfp_host_model.stray();
      run(1, 1'b0, 1'b1);
      $display("test deselected done");
      pulse(2, 8'h00);
      fork
         i_sfp_host_model.frame(8'h5a, 1, 1'b0, 8'h3c, rd);
         begin
            repeat (30) @(posedge i_ref_clk);
            pulse(RCYC + 6, 8'h01);
         end
      join
      run(1, 1'b0, 1'b1);
      $display("test hw_reset done");
      repeat (10) @(posedge i_ref_clk);
      check(8'(op_q.size() + rx_q.size()), 8'h00);
      check(8'(tx_cnt), 8'(tx_exp));
      check({7'h0, sel_cyc > 0}, 8'h01);
      summarize();
   end
endmodule
